// File: hdl/blt_tuning_regs.sv
// link tuning, subsystem alias and general control configuration registers
// Notes on behaviour
// - standby timer counts 62.5 MHz ticks
// - standby timer resets to 0010
// - separate clocking sends count from 31:24
// - shared clocking sends count from 23:16
// - bit 7 enables deep sleep saving
// - bit 5 enables first window, reset off
// - bit 6 always reads zero
// - high half aliases subsystem identifier
// - low half aliases subsystem maker identifier
// - all three resets restore defaults
// - second control at C8h, default 32142000h
// - subsystem access at D0h, resets zero
// - general control at D4h, default 8600025Fh
// - sleep timer counts 512 ns, resets 0100
module blt_tuning_regs
  import blt_pkg::*;
#(
  parameter logic [2:0] PHYS_REV = PHYS_REV_VALUE
) (
  input wire logic core_clk, // core clock, 200 MHz
  input wire logic rst_b, // power-on reset, async, active low
  input wire logic fund_reset_b, // link fundamental reset, active low
  input wire logic global_reset_input_b, // global reset, active low
  input wire blt_cfg_req_t cfg_req, // configuration access from host
  input wire blt_cfg_req_t eeprom_req, // register load from eeprom
  output logic [31:0] cfg_rdata, // read data, valid with cfg_rd_ack
  output logic cfg_rd_ack, // one-cycle read answer
  output logic cfg_wr_lost, // host write dropped for eeprom load
  input wire logic common_clk_cfg, // shared reference clock configured
  input wire logic link_idle, // link has no traffic
  input wire logic in_l2, // link sits in the L2 state
  output logic standby_entry_req, // idle long enough for L0s
  output logic sleep_entry_req, // idle long enough for L1
  output logic deep_sleep_active, // power saving applied in L2
  output blt_tune_t tune // registered settings for the link
);

  logic [31:0] ctl_one;
  logic [31:0] ctl_two;
  logic [31:0] subsys;
  logic [31:0] gen_ctl;

  // ---------------- request selection and decode ----------------
  wire soft_clear;
  wire use_eeprom;
  wire blt_cfg_req_t wreq;
  wire do_write;
  wire [5:0] wr_dw;
  wire [5:0] rd_dw;
  wire [31:0] be_mask;
  wire hit_w_ctl_one;
  wire hit_w_ctl_two;
  wire hit_w_subsys;
  wire hit_w_gen_ctl;
  wire hit_r_alias;
  wire hit_r_ctl_one;
  wire hit_r_ctl_two;
  wire hit_r_subsys;
  wire hit_r_gen_ctl;

  // the link and global resets act like power-on reset on every field
  assign soft_clear = !fund_reset_b || !global_reset_input_b;

  // eeprom loading owns the register file while it writes
  assign use_eeprom = eeprom_req.wr;
  assign wreq = use_eeprom ? eeprom_req : cfg_req;
  assign do_write = wreq.wr && !soft_clear;
  assign wr_dw = wreq.addr[7:2];
  assign rd_dw = cfg_req.addr[7:2];

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign be_mask[lane*8 +: 8] = {8{wreq.be[lane]}};
    end
  endgenerate

  assign hit_w_ctl_one = do_write && wr_dw == OFS_CTL_ONE[7:2];
  assign hit_w_ctl_two = do_write && wr_dw == OFS_CTL_TWO[7:2];
  assign hit_w_subsys = do_write && wr_dw == OFS_SUBSYS_ACCESS[7:2];
  assign hit_w_gen_ctl = do_write && wr_dw == OFS_GEN_CTL[7:2];

  assign hit_r_alias = rd_dw == OFS_SUBSYS_ALIAS[7:2];
  assign hit_r_ctl_one = rd_dw == OFS_CTL_ONE[7:2];
  assign hit_r_ctl_two = rd_dw == OFS_CTL_TWO[7:2];
  assign hit_r_subsys = rd_dw == OFS_SUBSYS_ACCESS[7:2];
  assign hit_r_gen_ctl = rd_dw == OFS_GEN_CTL[7:2];

  // ---------------- write merge ----------------
  wire [31:0] next_ctl_one;
  wire [31:0] next_ctl_two;
  wire [31:0] next_subsys;
  wire [31:0] next_gen_ctl;
  wire [31:0] m_ctl_one;
  wire [31:0] m_ctl_two;
  wire [31:0] m_subsys;
  wire [31:0] m_gen_ctl;

  // bits outside the write masks never change, so read-only fields and
  // the always-zero reserved bit keep their reset value
  assign m_ctl_one = be_mask & WMASK_CTL_ONE;
  assign m_ctl_two = be_mask & WMASK_CTL_TWO;
  assign m_subsys = be_mask & WMASK_SUBSYS;
  assign m_gen_ctl = be_mask & WMASK_GEN_CTL;

  assign next_ctl_one = hit_w_ctl_one ?
    (ctl_one & ~m_ctl_one) | (wreq.wdata & m_ctl_one) : ctl_one;
  assign next_ctl_two = hit_w_ctl_two ?
    (ctl_two & ~m_ctl_two) | (wreq.wdata & m_ctl_two) : ctl_two;
  assign next_subsys = hit_w_subsys ?
    (subsys & ~m_subsys) | (wreq.wdata & m_subsys) : subsys;
  assign next_gen_ctl = hit_w_gen_ctl ?
    (gen_ctl & ~m_gen_ctl) | (wreq.wdata & m_gen_ctl) : gen_ctl;

  // the link and global resets reload defaults synchronously, so a pulse
  // shorter than one core cycle can be missed; power-on reset is async
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_one <= RST_CTL_ONE;
    end else if (soft_clear) begin
      ctl_one <= RST_CTL_ONE;
    end else begin
      ctl_one <= next_ctl_one;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_two <= RST_CTL_TWO;
    end else if (soft_clear) begin
      ctl_two <= RST_CTL_TWO;
    end else begin
      ctl_two <= next_ctl_two;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      subsys <= RST_SUBSYS;
    end else if (soft_clear) begin
      subsys <= RST_SUBSYS;
    end else begin
      subsys <= next_subsys;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gen_ctl <= RST_GEN_CTL;
    end else if (soft_clear) begin
      gen_ctl <= RST_GEN_CTL;
    end else begin
      gen_ctl <= next_gen_ctl;
    end
  end

  // ---------------- read path ----------------
  wire [31:0] ctl_two_view;
  wire [31:0] rd_value;
  wire next_rd_ack;
  wire next_wr_lost;

  // revision comes from the parameter, not from storage
  assign ctl_two_view = {ctl_two[31:REV_LSB+REV_W], PHYS_REV,
                         ctl_two[REV_LSB-1:0]};

  // the 44h dword holds both identifier registers, so it is the same
  // word as the access register
  assign rd_value = hit_r_alias ? subsys :
                    hit_r_ctl_one ? ctl_one :
                    hit_r_ctl_two ? ctl_two_view :
                    hit_r_subsys ? subsys :
                    hit_r_gen_ctl ? gen_ctl :
                    32'h0000_0000;

  assign next_rd_ack = cfg_req.rd && !soft_clear;
  assign next_wr_lost = use_eeprom && cfg_req.wr && !soft_clear;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_rd_ack <= 1'b0;
    end else begin
      cfg_rdata <= next_rd_ack ? rd_value : 32'h0000_0000;
      cfg_rd_ack <= next_rd_ack;
    end
  end

  // the host gets no retry for a dropped write; it must watch this pulse
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_wr_lost <= 1'b0;
    end else begin
      cfg_wr_lost <= next_wr_lost;
    end
  end

  // ---------------- settings to the link ----------------
  wire [7:0] fts_separate;
  wire [7:0] fts_shared;
  wire [2:0] lat_separate;
  wire [2:0] lat_shared;
  wire [STANDBY_W-1:0] standby_limit;
  wire [SLEEP_W-1:0] sleep_limit;
  wire [LINK_W-1:0] link_field;
  wire deep_sleep_field;
  wire window_field;
  wire sbus_mask_field;
  wire [15:0] ident_field;
  wire [15:0] maker_field;
  blt_tune_t next_tune;
  wire next_deep_sleep;

  assign fts_separate = ctl_two[FTS_SEPARATE_LSB +: FTS_W];
  assign fts_shared = ctl_two[FTS_SHARED_LSB +: FTS_W];
  assign lat_separate = ctl_one[LAT_SEPARATE_LSB +: LAT_W];
  assign lat_shared = ctl_one[LAT_SHARED_LSB +: LAT_W];
  assign standby_limit = ctl_one[STANDBY_LSB +: STANDBY_W];
  assign sleep_limit = ctl_one[SLEEP_LSB +: SLEEP_W];
  assign link_field = ctl_two[LINK_LSB +: LINK_W];
  assign deep_sleep_field = ctl_two[DEEP_SLEEP_BIT];
  assign window_field = ctl_two[WINDOW_EN_BIT];
  assign sbus_mask_field = ctl_one[SBUS_MASK_BIT];
  assign ident_field = subsys[SUBSYS_IDENT_LSB +: 16];
  assign maker_field = subsys[SUBSYS_MAKER_LSB +: 16];

  always_comb begin
    next_tune = '0;
    next_tune.fast_train_count = common_clk_cfg ?
      fts_shared : fts_separate;
    next_tune.link_number = link_field;
    next_tune.deep_sleep_saving_enable = deep_sleep_field;
    next_tune.first_window_enable = window_field;
    // mirror follows the shared-clock bit in the sense the register
    // defines it, which looks swapped but is kept as specified
    next_tune.l1_exit_latency = common_clk_cfg ? lat_separate : lat_shared;
    next_tune.sbus_reset_mask = sbus_mask_field;
    next_tune.subsys_ident_alias = ident_field;
    next_tune.subsys_maker_alias = maker_field;
    next_tune.general_control = gen_ctl;
  end

  assign next_deep_sleep = in_l2 && deep_sleep_field;

  // settings lag their register by one cycle; the link side only reads
  // them between transfers, so the extra flop costs nothing
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tune <= '0;
    end else begin
      tune <= next_tune;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      deep_sleep_active <= 1'b0;
    end else begin
      deep_sleep_active <= next_deep_sleep;
    end
  end

  // ---------------- entry timers ----------------
  blt_entry_timer #(
    .TICK_NS(STANDBY_TICK_NS),
    .STEP_NS(CLK_PERIOD_NS),
    .LIMIT_W(STANDBY_W)
  ) u_standby_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clear(soft_clear),
    .idle(link_idle),
    .limit(standby_limit),
    .entry_req(standby_entry_req)
  );

  blt_entry_timer #(
    .TICK_NS(SLEEP_TICK_NS),
    .STEP_NS(CLK_PERIOD_NS),
    .LIMIT_W(SLEEP_W)
  ) u_sleep_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clear(soft_clear),
    .idle(link_idle),
    .limit(sleep_limit),
    .entry_req(sleep_entry_req)
  );

endmodule

// File: hdl/blt_pkg.sv
// constants and carrier types for the bridge link tuning registers
package blt_pkg;

  // core clock and the tick periods of the two entry timers
  localparam int CLK_PERIOD_NS = 5;
  localparam int STANDBY_TICK_NS = 16;
  localparam int SLEEP_TICK_NS = 512;

  // configuration offsets (byte addresses of dword registers)
  localparam logic [7:0] OFS_SUBSYS_ALIAS = 8'h44;
  localparam logic [7:0] OFS_CTL_ONE = 8'hc4;
  localparam logic [7:0] OFS_CTL_TWO = 8'hc8;
  localparam logic [7:0] OFS_SUBSYS_ACCESS = 8'hd0;
  localparam logic [7:0] OFS_GEN_CTL = 8'hd4;

  // values after reset
  localparam logic [31:0] RST_CTL_ONE = 32'h0012_0108;
  localparam logic [31:0] RST_CTL_TWO = 32'h3214_2000;
  localparam logic [31:0] RST_SUBSYS = 32'h0000_0000;
  localparam logic [31:0] RST_GEN_CTL = 32'h8600_025f;

  // writable bits; everything else keeps its reset value
  localparam logic [31:0] WMASK_CTL_ONE = 32'h001f_ffff;
  localparam logic [31:0] WMASK_CTL_TWO = 32'hffff_1fbf;
  localparam logic [31:0] WMASK_SUBSYS = 32'hffff_ffff;
  localparam logic [31:0] WMASK_GEN_CTL = 32'hfeff_ffff;

  // first control register fields
  localparam int STANDBY_LSB = 2;
  localparam int STANDBY_W = 4;
  localparam int SLEEP_LSB = 6;
  localparam int SLEEP_W = 4;
  localparam int SBUS_MASK_BIT = 10;
  localparam int LAT_SHARED_LSB = 15;
  localparam int LAT_SEPARATE_LSB = 18;
  localparam int LAT_W = 3;

  // second control register fields
  localparam int FTS_SEPARATE_LSB = 24;
  localparam int FTS_SHARED_LSB = 16;
  localparam int FTS_W = 8;
  localparam int REV_LSB = 13;
  localparam int REV_W = 3;
  localparam logic [2:0] PHYS_REV_VALUE = 3'h1;
  localparam int LINK_LSB = 8;
  localparam int LINK_W = 5;
  localparam int DEEP_SLEEP_BIT = 7;
  localparam int CTL2_RSVD_BIT = 6;
  localparam int WINDOW_EN_BIT = 5;

  // subsystem access fields
  localparam int SUBSYS_IDENT_LSB = 16;
  localparam int SUBSYS_MAKER_LSB = 0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } blt_cfg_req_t;

  typedef struct packed {
    logic [7:0] fast_train_count;
    logic [4:0] link_number;
    logic deep_sleep_saving_enable;
    logic first_window_enable;
    logic [2:0] l1_exit_latency;
    logic sbus_reset_mask;
    logic [15:0] subsys_ident_alias;
    logic [15:0] subsys_maker_alias;
    logic [31:0] general_control;
  } blt_tune_t;

endpackage

// File: hdl/blt_entry_timer.sv
// idle-entry timer counting fractional-rate ticks derived from core_clk
module blt_entry_timer
  import blt_pkg::*;
#(
  parameter int TICK_NS = 16,
  parameter int STEP_NS = 5,
  parameter int LIMIT_W = 4
) (
  input wire logic core_clk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic clear, // sync clear from the link resets
  input wire logic idle, // link idle level
  input wire logic [LIMIT_W-1:0] limit, // ticks of idle before entry
  output logic entry_req // high once idle has lasted the limit
);

  localparam int ACC_W = $clog2(TICK_NS + STEP_NS) + 1;
  localparam logic [ACC_W-1:0] TICK_V = ACC_W'(TICK_NS);
  localparam logic [ACC_W-1:0] STEP_V = ACC_W'(STEP_NS);

  logic [ACC_W-1:0] acc;
  logic [LIMIT_W-1:0] ticks;
  logic [ACC_W-1:0] acc_sum;
  logic tick;
  logic [ACC_W-1:0] next_acc;
  logic [LIMIT_W-1:0] next_ticks;
  logic next_entry_req;

  // a phase accumulator gives the exact mean tick rate without a pll;
  // individual ticks jitter by one core cycle
  assign acc_sum = acc + STEP_V;
  assign tick = acc_sum >= TICK_V;
  assign next_acc = tick ? acc_sum - TICK_V : acc_sum;
  assign next_ticks = !idle ? '0 :
                      (tick && ticks != '1) ? ticks + 1'b1 : ticks;
  assign next_entry_req = idle && (ticks >= limit);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc <= '0;
      ticks <= '0;
      entry_req <= 1'b0;
    end else if (clear) begin
      acc <= '0;
      ticks <= '0;
      entry_req <= 1'b0;
    end else begin
      acc <= next_acc;
      ticks <= next_ticks;
      entry_req <= next_entry_req;
    end
  end

endmodule

// File: tb/blt_tuning_props.sv
// port assertions for the tuning register bank
module blt_tuning_props
  import blt_pkg::*;
#(
  parameter logic [2:0] PHYS_REV = PHYS_REV_VALUE
) (
  input wire logic core_clk, // clock
  input wire logic rst_b, // power-on reset
  input wire logic fund_reset_b, // link reset
  input wire logic global_reset_input_b, // global reset
  input wire blt_cfg_req_t cfg_req, // host access
  input wire blt_cfg_req_t eeprom_req, // eeprom load
  input wire logic [31:0] cfg_rdata, // read data
  input wire logic cfg_rd_ack, // read answer
  input wire logic cfg_wr_lost, // dropped write
  input wire logic common_clk_cfg, // shared clock
  input wire logic link_idle, // idle level
  input wire logic in_l2, // l2 state
  input wire logic standby_entry_req, // l0s request
  input wire logic sleep_entry_req, // l1 request
  input wire logic deep_sleep_active, // l2 saving
  input wire blt_tune_t tune // settings
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // sync resets drop requests, so only count accesses outside them
  wire logic live = fund_reset_b && global_reset_input_b;
  wire logic rd_c8 = live && cfg_req.rd && cfg_req.addr[7:2] == 6'h32;

  read_answer_a: assert property (
    live && cfg_req.rd |=> cfg_rd_ack) else $error("read not answered");
  quiet_data_a: assert property (
    !cfg_req.rd |=> !cfg_rd_ack && cfg_rdata == 32'h0000_0000)
    else $error("stray read answer");
  fixed_bits_a: assert property (
    rd_c8 |=> cfg_rdata[6] == 1'b0 && cfg_rdata[15:13] == PHYS_REV)
    else $error("fixed bits wrong");
  sep_count_a: assert property (
    !fund_reset_b ##1 !fund_reset_b && !common_clk_cfg
    |=> tune.fast_train_count == 8'h32) else $error("separate count");
  shared_count_a: assert property (
    !fund_reset_b ##1 !fund_reset_b && common_clk_cfg
    |=> tune.fast_train_count == 8'h14) else $error("shared count");
  window_off_a: assert property (
    !global_reset_input_b [*2] |=> !tune.first_window_enable &&
    tune.subsys_ident_alias == 16'h0000 &&
    tune.general_control == 32'h8600_025f) else $error("reset values");
  deep_sleep_a: assert property (
    live && $past(live) |-> deep_sleep_active ==
    ($past(in_l2) && tune.deep_sleep_saving_enable))
    else $error("deep sleep wrong");
  lost_write_a: assert property (
    cfg_wr_lost == $past(live && cfg_req.wr && eeprom_req.wr))
    else $error("lost write flag");
  idle_drop_a: assert property (
    !link_idle |=> !standby_entry_req && !sleep_entry_req)
    else $error("request without idle");

  cover property (cfg_rd_ack);
  cover property (cfg_wr_lost);
  cover property (sleep_entry_req);
endmodule

// File: tb/blt_host_model.sv
// host issuing one configuration access at a time
module blt_host_model
  import blt_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic [31:0] cfg_rdata, // read data
  input wire logic cfg_rd_ack, // read answer
  output blt_cfg_req_t cfg_req // request
);
  timeunit 1ns;
  timeprecision 100ps;
  initial cfg_req = '0;

  // q returns {ack, data} seen in the answer cycle
  task automatic access(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [32:0] q);
    if (a == 8'hc4) d[1:0] = 2'h0;
    if (a == 8'hc8) d[4:0] = 5'h00;
    @(posedge core_clk);
    cfg_req <= '{w, !w, a, 4'hf, d};
    @(posedge core_clk);
    // idle fields flip so stale values cannot pass for data
    cfg_req <= '{1'b0, 1'b0, ~a, 4'h0, ~d};
    @(negedge core_clk);
    q = {cfg_rd_ack, cfg_rdata};
  endtask
endmodule

// File: tb/blt_tuning_regs_tb.sv
// self-checking bench for the tuning register bank
`define CHK(g, e) cmp(64'(g), 64'(e))
module blt_tuning_regs_tb
  import blt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst_b, fund_reset_b, global_reset_input_b;
  logic common_clk_cfg, link_idle, in_l2;
  logic cfg_rd_ack, cfg_wr_lost, standby_entry_req, sleep_entry_req;
  logic deep_sleep_active;
  logic [31:0] cfg_rdata;
  blt_cfg_req_t cfg_req, eeprom_req;
  blt_tune_t tune;
  int n_mismatch = 0;
  int n_checks = 0;
  int ns, nl, st, sl;
  logic [31:0] m[4];
  logic [31:0] dflt[4] = '{32'h0012_0108, 32'h3214_2000, 32'h0000_0000,
    32'h8600_025f};
  logic [31:0] wm[4] = '{32'h001f_ffff, 32'hffff_1fbf, 32'hffff_ffff,
    32'hfeff_ffff};
  logic [31:0] lim[3] = '{32'h0012_0108, 32'h0012_007c, 32'h0012_0040};
  logic [7:0] adr[$] = '{8'hc4, 8'hc8, 8'hd0, 8'hd4, 8'h44, 8'h40, 8'hfc};

  blt_host_model i_host (.core_clk(core_clk), .cfg_rdata(cfg_rdata),
    .cfg_rd_ack(cfg_rd_ack), .cfg_req(cfg_req));
  blt_tuning_regs i_dut (.core_clk(core_clk), .rst_b(rst_b),
    .fund_reset_b(fund_reset_b), .global_reset_input_b(global_reset_input_b),
    .cfg_req(cfg_req), .eeprom_req(eeprom_req), .cfg_rdata(cfg_rdata),
    .cfg_rd_ack(cfg_rd_ack), .cfg_wr_lost(cfg_wr_lost),
    .common_clk_cfg(common_clk_cfg), .link_idle(link_idle), .in_l2(in_l2),
    .standby_entry_req(standby_entry_req), .sleep_entry_req(sleep_entry_req),
    .deep_sleep_active(deep_sleep_active), .tune(tune));

  task automatic cmp(logic [63:0] g, logic [63:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask

  function automatic logic [31:0] exp_rd(logic [7:0] a);
    case (a)
      8'h44, 8'hd0: return m[2];
      8'hc4: return m[0];
      8'hc8: return m[1];
      8'hd4: return m[3];
      default: return 32'h0000_0000;
    endcase
  endfunction

  task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
    logic [32:0] q;
    int i;
    if (a == 8'hc4) d[1:0] = 2'h0;
    if (a == 8'hc8) d[4:0] = 5'h00;
    i_host.access(w, a, d, q);
    `CHK(q, {~w, w ? 32'h0000_0000 : exp_rd(a)});
    i = a == 8'hc4 ? 0 : a == 8'hc8 ? 1 : a == 8'hd0 ? 2 : a == 8'hd4 ? 3 : 4;
    if (w && i < 4) m[i] = (m[i] & ~wm[i]) | (d & wm[i]);
  endtask

  task automatic done(string s);
    $display("test %s done", s);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (20_000) @(posedge core_clk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    {rst_b, fund_reset_b, global_reset_input_b} = 3'h3;
    {common_clk_cfg, link_idle, in_l2} = 3'h0;
    eeprom_req = '0;
    m = dflt;
    void'($urandom(32'h71db_bd35));
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (adr[j]) acc(1'b0, adr[j], 32'h0000_0000);
    done("defaults");
    for (int k = 0; k < 30; k++) begin
      @(posedge core_clk);
      common_clk_cfg <= 1'($urandom_range(1));
      in_l2 <= 1'($urandom_range(1));
      acc(1'b1, adr[$urandom_range(6)], $urandom);
      foreach (adr[j]) acc(1'b0, adr[j], 32'h0000_0000);
      `CHK(tune.fast_train_count, common_clk_cfg ? m[1][23:16] : m[1][31:24]);
      `CHK({tune.link_number, tune.first_window_enable}, {m[1][12:8], m[1][5]});
      `CHK({tune.subsys_ident_alias, tune.subsys_maker_alias}, m[2]);
      `CHK(tune.general_control, m[3]);
      `CHK(tune.sbus_reset_mask, m[0][10]);
      `CHK(tune.l1_exit_latency, m[0] >> (common_clk_cfg ? 18 : 15) & 7);
      `CHK(deep_sleep_active, in_l2 & m[1][7]);
    end
    done("random");
    foreach (lim[j]) begin
      acc(1'b1, 8'hc4, lim[j]);
      st = m[0][5:2] * 16 / 5;
      sl = m[0][9:6] * 512 / 5;
      ns = -1;
      nl = -1;
      @(posedge core_clk);
      link_idle <= 1'b1;
      for (int c = 1; c < 600; c++) begin
        @(negedge core_clk);
        if (standby_entry_req === 1'b1 && ns < 0) ns = c;
        if (sleep_entry_req === 1'b1 && nl < 0) nl = c;
      end
      // tick phase is free, so allow one tick early
      `CHK(ns >= st - 4 && ns <= st + 4, 1'b1);
      `CHK(nl >= sl - 103 && nl <= sl + 4, 1'b1);
      @(posedge core_clk);
      link_idle <= 1'b0;
      repeat (2) @(negedge core_clk);
      `CHK({standby_entry_req, sleep_entry_req}, 2'h0);
    end
    done("timers");
    fork
      acc(1'b1, 8'hd0, 32'h1111_2222);
      begin
        @(posedge core_clk);
        eeprom_req <= '{1'b1, 1'b0, 8'hd0, 4'hf, 32'h5a5a_0f0f};
        @(posedge core_clk);
        eeprom_req <= '0;
      end
    join
    `CHK(cfg_wr_lost, 1'b1);
    m[2] = 32'h5a5a_0f0f;
    acc(1'b0, 8'h44, 32'h0000_0000);
    done("eeprom");
    for (int r = 0; r < 4; r++) begin
      acc(1'b1, 8'hc8, $urandom);
      acc(1'b1, 8'hd0, $urandom);
      @(posedge core_clk);
      common_clk_cfg <= r[0];
      if (r < 2) fund_reset_b <= 1'b0;
      else if (r == 2) global_reset_input_b <= 1'b0;
      else rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      {rst_b, fund_reset_b, global_reset_input_b} <= 3'h7;
      m = dflt;
      foreach (adr[j]) acc(1'b0, adr[j], 32'h0000_0000);
      `CHK(tune.fast_train_count, r[0] ? 8'h14 : 8'h32);
    end
    done("resets");
    end_sim();
  end
endmodule

bind blt_tuning_regs blt_tuning_props #(.PHYS_REV(PHYS_REV)) i_props (
  .core_clk(core_clk), .rst_b(rst_b), .fund_reset_b(fund_reset_b),
  .global_reset_input_b(global_reset_input_b), .cfg_req(cfg_req),
  .eeprom_req(eeprom_req), .cfg_rdata(cfg_rdata), .cfg_rd_ack(cfg_rd_ack),
  .cfg_wr_lost(cfg_wr_lost), .common_clk_cfg(common_clk_cfg),
  .link_idle(link_idle), .in_l2(in_l2), .tune(tune),
  .standby_entry_req(standby_entry_req), .sleep_entry_req(sleep_entry_req),
  .deep_sleep_active(deep_sleep_active));
